// ### inc/tmtc_pkg.sv
package tmtc_pkg;
    // ========================================
    // register addresses
    localparam logic [15:0] mode_ctrl_addr    = 16'hff48;
    localparam logic [15:0] tone_ctrl_addr    = 16'hff49;
    localparam logic [15:0] counter_lo_addr   = 16'hff4a;
    localparam logic [15:0] counter_hi_addr   = 16'hff4b;
    localparam logic [15:0] match_lo_addr     = 16'hff4c;
    localparam logic [15:0] match_hi_addr     = 16'hff4d;
    localparam logic [15:0] capture_lo_addr   = 16'hff4e;
    localparam logic [15:0] capture_hi_addr   = 16'hff4f;
    // ========================================
    // reset values
    localparam logic [7:0]  mode_ctrl_reset   = 8'h00;
    localparam logic [7:0]  tone_ctrl_reset   = 8'h00;
    localparam logic [15:0] match_reset       = 16'hffff;
    localparam logic [15:0] counter_reset     = 16'h0000;
    // ========================================
    // mode control field positions
    localparam int output_level_pos  = 7;
    localparam int overflow_pos      = 6;
    localparam int capture_edge_pos  = 4;
    localparam int toggle_enable_pos = 3;
    localparam int count_clock_pos   = 1;
    localparam int output_enable_pos = 0;
    // tone control field positions
    localparam int tone_div_pos      = 1;
    localparam int tone_enable_pos   = 0;
    localparam logic [7:0] tone_ctrl_mask = 8'h0f;
    // ========================================
    // count clock divide ratios of the main clock
    localparam logic [7:0] div_main4   = 8'h03;
    localparam logic [7:0] div_main64  = 8'h3f;
    localparam logic [7:0] div_main128 = 8'h7f;
    localparam int capture_latency_cycles = 2;
    typedef enum logic [1:0]
    {
        clk_main4   = 2'b00,
        clk_main64  = 2'b01,
        clk_main128 = 2'b10,
        clk_sub     = 2'b11
    } tmtc_clksel_type;
    typedef enum logic [1:0]
    {
        edge_off  = 2'b00,
        edge_rise = 2'b01,
        edge_fall = 2'b10,
        edge_both = 2'b11
    } tmtc_edge_type;
endpackage

// ### verilog/tmtc_tone_gen.sv
module tmtc_tone_gen
(
    input  wire logic       ref_clk,   // system clock
    input  wire logic       srst,      // synchronous reset
    input  wire logic       tick,      // count clock enable pulse
    input  wire logic [2:0] div_sel,   // divider select code
    output logic            tone       // square wave
);
    logic [12:0] pre_reg;
    logic [12:0] pre_next;
    logic        tone_reg;
    logic        tone_next;
    logic [3:0]  tap;

    // ========================================
    // half-period tap: divide by 2^(tap+1)
    always_comb
    begin
        case (div_sel)
            3'b000:  tap = 4'h3;
            3'b001:  tap = 4'h4;
            3'b010:  tap = 4'h7;
            3'b011:  tap = 4'h8;
            3'b100:  tap = 4'h9;
            3'b101:  tap = 4'ha;
            3'b110:  tap = 4'hb;
            default: tap = 4'hc;
        endcase
        pre_next  = pre_reg;
        tone_next = tone_reg;
        if (tick)
        begin
            pre_next  = pre_reg + 13'h0001;
            tone_next = pre_next[tap];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            pre_reg  <= 13'h0000;
            tone_reg <= 1'b0;
        end
        else
        begin
            pre_reg  <= pre_next;
            tone_reg <= tone_next;
        end
    end

    assign tone = tone_reg;
endmodule

// ### verilog/tmtc_timer.sv
// How it works
// - reset clears the mode control register to zero
// - mode control accepts bit and byte writes
// - overflow flag bit 6 sets on overflow, stays until reset or cleared
// - capture edge field: off, rising, falling, both edges
// - toggle enable bit blocks or permits output inversion
// - count clock select: main/4, main/64, main/128, subclock
// - output enable off leaves port pin, on drives timer level
// - reset clears tone control register to zero
// - tone divides count clock by 16 up to 8192
// - tone pin enable puts tone on its pin
// - subclock with tone enabled disables capture and counter readout
// - counter runs freely, not cleared on match
// - match raises irq and toggles output when inversion and output enable are both set
// - capture copies counter within two clocks, held until next edge
module tmtc_timer
(
    input  wire logic        ref_clk,        // 50 MHz clock
    input  wire logic        srst,           // synchronous reset
    input  wire logic [15:0] addr,           // register address
    input  wire logic        wr_en,          // write strobe
    input  wire logic        rd_en,          // read strobe
    input  wire logic [7:0]  wdata,          // write data byte
    input  wire logic [7:0]  bit_mask,       // lanes written, all ones for byte
    output logic [7:0]       rdata,          // read data
    input  wire logic        subclock_tick,  // subclock edge pulse
    input  wire logic        capture_input_pin, // capture input
    input  wire logic        port_latch,     // port value when timer output off
    output logic             timer_out_pin,  // timer output pin
    output logic             tone_out_pin,   // tone output pin
    output logic             match_irq       // match request pulse
);
    logic [7:0]  mode_reg;
    logic [7:0]  mode_next;
    logic [7:0]  tone_reg;
    logic [7:0]  tone_next;
    logic [15:0] free_counter_reg;
    logic [15:0] free_counter_next;
    logic [15:0] match_value_reg;
    logic [15:0] match_value_next;
    logic [15:0] capture_value_reg;
    logic [15:0] capture_value_next;
    logic [7:0]  read_hold_reg;
    logic [7:0]  read_hold_next;
    logic        out_level_reg;
    logic        out_level_next;
    logic        cap_prev_reg;
    logic        cap_prev_next;
    logic        irq_reg;
    logic        irq_next;
    logic [7:0]  div_reg;
    logic [7:0]  div_next;
    logic [7:0]  rdata_reg;
    logic [7:0]  rdata_next;
    logic        tick;
    logic        overflow;
    logic        match_hit;
    logic        cap_edge;
    logic        unsync;
    logic        tone;
    logic [7:0]  div_limit;
    tmtc_pkg::tmtc_clksel_type clk_sel;
    tmtc_pkg::tmtc_edge_type   edge_sel;

    function automatic logic [7:0] merge(input logic [7:0] old_v, input logic [7:0] new_v,
                                         input logic [7:0] m);
        merge = (old_v & ~m) | (new_v & m);
    endfunction

    assign clk_sel  = tmtc_pkg::tmtc_clksel_type'(mode_reg[tmtc_pkg::count_clock_pos +: 2]);
    assign edge_sel = tmtc_pkg::tmtc_edge_type'(mode_reg[tmtc_pkg::capture_edge_pos +: 2]);
    assign unsync   = (clk_sel == tmtc_pkg::clk_sub) && tone_reg[tmtc_pkg::tone_enable_pos];

    // ========================================
    // count clock divider
    always_comb
    begin
        case (clk_sel)
            tmtc_pkg::clk_main4:   div_limit = tmtc_pkg::div_main4;
            tmtc_pkg::clk_main64:  div_limit = tmtc_pkg::div_main64;
            tmtc_pkg::clk_main128: div_limit = tmtc_pkg::div_main128;
            default:               div_limit = 8'h00;
        endcase
        if (clk_sel == tmtc_pkg::clk_sub)
        begin
            tick     = subclock_tick;
            div_next = 8'h00;
        end
        else
        begin
            tick     = (div_reg >= div_limit);
            div_next = tick ? 8'h00 : div_reg + 8'h01;
        end
    end

    // ========================================
    // counter, match, capture, output level
    always_comb
    begin
        overflow  = tick && (free_counter_reg == 16'hffff);
        match_hit = tick && (free_counter_reg + 16'h0001 == match_value_reg);
        case (edge_sel)
            tmtc_pkg::edge_rise: cap_edge = capture_input_pin & ~cap_prev_reg;
            tmtc_pkg::edge_fall: cap_edge = ~capture_input_pin & cap_prev_reg;
            tmtc_pkg::edge_both: cap_edge = capture_input_pin ^ cap_prev_reg;
            default:             cap_edge = 1'b0;
        endcase
        cap_prev_next = capture_input_pin;
        // free run, no clear on match
        free_counter_next = tick ? free_counter_reg + 16'h0001 : free_counter_reg;
        // capture within two clocks; disabled when unsynced
        capture_value_next = (cap_edge && !unsync) ? free_counter_reg : capture_value_reg;
        // match irq and toggle; toggle gate
        irq_next       = match_hit;
        out_level_next = out_level_reg;
        if (!mode_reg[tmtc_pkg::output_enable_pos])
            out_level_next = 1'b0;
        else if (match_hit && mode_reg[tmtc_pkg::toggle_enable_pos])
            out_level_next = ~out_level_reg;
    end

    // ========================================
    // register writes and reads
    always_comb
    begin
        mode_next        = mode_reg;
        tone_next        = tone_reg;
        match_value_next = match_value_reg;
        read_hold_next   = read_hold_reg;
        rdata_next       = rdata_reg;
        if (wr_en)
        begin
            case (addr)
                tmtc_pkg::mode_ctrl_addr: mode_next = merge(mode_reg, wdata, bit_mask);
                tmtc_pkg::tone_ctrl_addr:
                    tone_next = merge(tone_reg, wdata, bit_mask) & tmtc_pkg::tone_ctrl_mask;
                tmtc_pkg::match_lo_addr:
                    match_value_next[7:0] = merge(match_value_reg[7:0], wdata, bit_mask);
                tmtc_pkg::match_hi_addr:
                    match_value_next[15:8] = merge(match_value_reg[15:8], wdata, bit_mask);
                default: ;
            endcase
        end
        mode_next[tmtc_pkg::output_level_pos] = out_level_next;
        // overflow sets, set wins over clear
        if (overflow)
            mode_next[tmtc_pkg::overflow_pos] = 1'b1;
        if (rd_en)
        begin
            case (addr)
                tmtc_pkg::mode_ctrl_addr: rdata_next = mode_reg;
                tmtc_pkg::tone_ctrl_addr: rdata_next = tone_reg;
                tmtc_pkg::counter_lo_addr:
                begin
                    rdata_next     = unsync ? 8'h00 : free_counter_reg[7:0];
                    read_hold_next = unsync ? 8'h00 : free_counter_reg[15:8];
                end
                tmtc_pkg::counter_hi_addr: rdata_next = read_hold_reg;
                tmtc_pkg::match_lo_addr:   rdata_next = match_value_reg[7:0];
                tmtc_pkg::match_hi_addr:   rdata_next = match_value_reg[15:8];
                tmtc_pkg::capture_lo_addr: rdata_next = capture_value_reg[7:0];
                tmtc_pkg::capture_hi_addr: rdata_next = capture_value_reg[15:8];
                default:                   rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            mode_reg          <= tmtc_pkg::mode_ctrl_reset;
            tone_reg          <= tmtc_pkg::tone_ctrl_reset;
            free_counter_reg  <= tmtc_pkg::counter_reset;
            match_value_reg   <= tmtc_pkg::match_reset;
            capture_value_reg <= 16'h0000;
            read_hold_reg     <= 8'h00;
            out_level_reg     <= 1'b0;
            cap_prev_reg      <= 1'b0;
            irq_reg           <= 1'b0;
            div_reg           <= 8'h00;
            rdata_reg         <= 8'h00;
        end
        else
        begin
            mode_reg          <= mode_next;
            tone_reg          <= tone_next;
            free_counter_reg  <= free_counter_next;
            match_value_reg   <= match_value_next;
            capture_value_reg <= capture_value_next;
            read_hold_reg     <= read_hold_next;
            out_level_reg     <= out_level_next;
            cap_prev_reg      <= cap_prev_next;
            irq_reg           <= irq_next;
            div_reg           <= div_next;
            rdata_reg         <= rdata_next;
        end
    end

    // ========================================
    // tone generator
    // tone divider
    tmtc_tone_gen i_tmtc_tone_gen
    (
        .ref_clk (ref_clk),
        .srst    (srst),
        .tick    (tick),
        .div_sel (tone_reg[tmtc_pkg::tone_div_pos +: 3]),
        .tone    (tone)
    );

    assign tone_out_pin  = tone & tone_reg[tmtc_pkg::tone_enable_pos];
    assign timer_out_pin = mode_reg[tmtc_pkg::output_enable_pos] ? out_level_reg : port_latch;
    assign match_irq     = irq_reg;
    assign rdata         = rdata_reg;

    // ========================================
    // assertions
    sequence s_overflow;
        overflow;
    endsequence

    a_overflow_sets: assert property (@(posedge ref_clk) disable iff (srst)
        s_overflow |=> mode_reg[tmtc_pkg::overflow_pos])
        else $error("overflow flag not set");
    a_overflow_sticky: assert property (@(posedge ref_clk) disable iff (srst)
        mode_reg[tmtc_pkg::overflow_pos] && !wr_en |=> mode_reg[tmtc_pkg::overflow_pos])
        else $error("overflow flag dropped");
    a_wrap_cause: assert property (@(posedge ref_clk) disable iff (srst)
        !$past(mode_reg[tmtc_pkg::overflow_pos]) && mode_reg[tmtc_pkg::overflow_pos]
        |-> free_counter_reg == 16'h0000)
        else $error("overflow without wrap");
    a_reset_clear: assert property (@(posedge ref_clk)
        srst |=> mode_reg == tmtc_pkg::mode_ctrl_reset && tone_reg == tmtc_pkg::tone_ctrl_reset)
        else $error("registers not cleared by reset");
    a_level_mirror: assert property (@(posedge ref_clk) disable iff (srst)
        mode_reg[tmtc_pkg::output_level_pos] == out_level_reg)
        else $error("output level bit mismatch");
    a_no_toggle_off: assert property (@(posedge ref_clk) disable iff (srst)
        !mode_reg[tmtc_pkg::toggle_enable_pos] && mode_reg[tmtc_pkg::output_enable_pos]
        && $past(mode_reg[tmtc_pkg::output_enable_pos]) |=> $stable(out_level_reg))
        else $error("output toggled with inversion off");
    a_match_irq: assert property (@(posedge ref_clk) disable iff (srst)
        match_irq |-> free_counter_reg == match_value_reg)
        else $error("irq without match");
    a_capture_take: assert property (@(posedge ref_clk) disable iff (srst)
        cap_edge && !unsync |-> ##[1:2] capture_value_reg == $past(free_counter_reg))
        else $error("capture value not taken");
    a_capture_hold: assert property (@(posedge ref_clk) disable iff (srst)
        !cap_edge |=> $stable(capture_value_reg))
        else $error("capture changed without edge");
    a_free_run: assert property (@(posedge ref_clk) disable iff (srst)
        tick && !wr_en |=> free_counter_reg == $past(free_counter_reg) + 16'h0001)
        else $error("counter did not advance");
    a_tone_gate: assert property (@(posedge ref_clk) disable iff (srst)
        !tone_reg[tmtc_pkg::tone_enable_pos] |-> !tone_out_pin)
        else $error("tone on pin while disabled");

    // match seen with output driven and inversion allowed
    sequence s_toggle_match;
        match_hit && mode_reg[tmtc_pkg::toggle_enable_pos]
        && mode_reg[tmtc_pkg::output_enable_pos];
    endsequence

    // counter low byte read while the subclock is unsynchronised
    sequence s_unsync_read;
        rd_en && (addr == tmtc_pkg::counter_lo_addr) && unsync;
    endsequence

    a_match_toggle: assert property (@(posedge ref_clk) disable iff (srst)
        s_toggle_match |=> out_level_reg != $past(out_level_reg))
        else $error("output not inverted on match");
    a_irq_pulse: assert property (@(posedge ref_clk) disable iff (srst)
        match_irq |=> !match_irq)
        else $error("match request longer than one cycle");
    a_level_idle: assert property (@(posedge ref_clk) disable iff (srst)
        !mode_reg[tmtc_pkg::output_enable_pos] |=> !out_level_reg)
        else $error("output level not low while output disabled");
    a_unsync_read: assert property (@(posedge ref_clk) disable iff (srst)
        s_unsync_read |=> rdata == 8'h00)
        else $error("counter readable while unsynchronised");
    a_capture_blocked: assert property (@(posedge ref_clk) disable iff (srst)
        cap_edge && unsync |=> $stable(capture_value_reg))
        else $error("capture taken while unsynchronised");
    a_byte_write: assert property (@(posedge ref_clk) disable iff (srst)
        wr_en && addr == tmtc_pkg::mode_ctrl_addr && bit_mask == 8'hff
        |=> mode_reg[5:0] == $past(wdata[5:0]))
        else $error("mode byte write not taken");
    a_count_hold: assert property (@(posedge ref_clk) disable iff (srst)
        !tick |=> $stable(free_counter_reg))
        else $error("counter moved without count clock");
endmodule

// ### verif/tmtc_pin_model.sv
module tmtc_pin_model
(
    input  wire logic ref_clk,           // 50 MHz clock
    input  wire logic srst,              // synchronous reset
    input  wire logic cap_req,           // capture level asked by bench
    output logic      capture_input_pin, // capture pin, synchronous
    output logic      subclock_tick      // subclock pulse every 2 clocks
);
    timeunit 1ns;
    timeprecision 1ns;
    // ========================================
    // pin drivers, one register stage
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            capture_input_pin <= 1'b0;
            subclock_tick     <= 1'b0;
        end
        else
        begin
            capture_input_pin <= cap_req;
            subclock_tick     <= ~subclock_tick;
        end
    end
endmodule

// ### verif/timer16_capture_tone_ctrl_bench.sv
module timer16_capture_tone_ctrl_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk, srst, wr_en, rd_en, port_latch, cap_req;
    logic [15:0] addr;
    logic [7:0]  wdata, bit_mask, rdata;
    logic        subclock_tick, capture_input_pin;
    logic        timer_out_pin, tone_out_pin, match_irq;
    int          failures, check_count;
    tmtc_timer i_tmtc_timer (.ref_clk(ref_clk), .srst(srst), .addr(addr),
        .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .bit_mask(bit_mask),
        .rdata(rdata), .subclock_tick(subclock_tick),
        .capture_input_pin(capture_input_pin), .port_latch(port_latch),
        .timer_out_pin(timer_out_pin), .tone_out_pin(tone_out_pin),
        .match_irq(match_irq));
    tmtc_pin_model i_tmtc_pin_model (.ref_clk(ref_clk), .srst(srst),
        .cap_req(cap_req), .capture_input_pin(capture_input_pin),
        .subclock_tick(subclock_tick));
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // ========================================
    // shared tasks
    task automatic final_report();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e)
        begin
            failures++;
            $display("unexpected %s: expected %h seen %h", name, e, g);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [7:0] m);
        @(posedge ref_clk);
        addr     <= a;
        wdata    <= d;
        bit_mask <= m;
        wr_en    <= 1'b1;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask
    // waits until tone (sel 1) or match_irq (sel 0) shows v
    task automatic wait_for(input bit sel, input logic v, input int lim, output int n);
        n = 0;
        do
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        while ((sel ? tone_out_pin : match_irq) !== v && n < lim);
        if ((sel ? tone_out_pin : match_irq) !== v)
        begin
            failures++;
            final_report();
        end
    endtask
    task automatic arm_match(output logic [15:0] m);
        logic [7:0] l, h;
        rd(tmtc_pkg::counter_lo_addr, l);
        rd(tmtc_pkg::counter_hi_addr, h);
        m = {h, l} + 16'h0028;
        wr(tmtc_pkg::match_lo_addr, m[7:0], 8'hff);
        wr(tmtc_pkg::match_hi_addr, m[15:8], 8'hff);
    endtask
    // ========================================
    // scenarios
    task automatic t_regs();
        logic [7:0] d;
        rd(tmtc_pkg::mode_ctrl_addr, d);
        chk("mode reset", 16'h0000, d);
        rd(tmtc_pkg::tone_ctrl_addr, d);
        chk("tone reset", 16'h0000, d);
        rd(16'hff50, d);
        chk("unmapped", 16'h0000, d);
        wr(tmtc_pkg::mode_ctrl_addr, 8'h80, 8'hff);
        rd(tmtc_pkg::mode_ctrl_addr, d);
        chk("level read only", 16'h0000, d);
        wr(tmtc_pkg::mode_ctrl_addr, 8'hff, 8'h10);
        rd(tmtc_pkg::mode_ctrl_addr, d);
        chk("bit write", 16'h0010, d);
        wr(tmtc_pkg::mode_ctrl_addr, 8'h02, 8'h02);
        rd(tmtc_pkg::mode_ctrl_addr, d);
        chk("second bit write", 16'h0012, d);
        wr(tmtc_pkg::mode_ctrl_addr, 8'h00, 8'hff);
        wr(tmtc_pkg::tone_ctrl_addr, 8'h0f, 8'hff);
        rd(tmtc_pkg::tone_ctrl_addr, d);
        chk("tone readback", 16'h000f, d);
        wr(tmtc_pkg::tone_ctrl_addr, 8'h00, 8'hff);
        $display("test regs done");
    endtask
    task automatic t_rates();
        int p[4] = '{4, 64, 128, 2};
        logic [7:0] a, b;
        for (int s = 0; s < 4; s++)
        begin
            wr(tmtc_pkg::mode_ctrl_addr, 8'(s << 1), 8'hff);
            repeat (130) @(posedge ref_clk);
            rd(tmtc_pkg::counter_lo_addr, a);
            repeat (10 * p[s] - 2) @(posedge ref_clk);
            rd(tmtc_pkg::counter_lo_addr, b);
            chk("ticks in ten periods", 16'h000a, 8'(b - a));
        end
        wr(tmtc_pkg::mode_ctrl_addr, 8'h00, 8'hff);
        $display("test rates done");
    endtask
    task automatic t_match();
        logic [15:0] m;
        logic [7:0]  c;
        int          n;
        arm_match(m);
        wr(tmtc_pkg::mode_ctrl_addr, 8'h09, 8'hff);
        wait_for(1'b0, 1'b1, 400, n);
        chk("toggled output", 16'h0001, timer_out_pin);
        @(posedge ref_clk);
        #1;
        chk("irq one cycle", 16'h0000, match_irq);
        rd(tmtc_pkg::counter_lo_addr, c);
        chk("counter runs on", 16'h0001, 8'(c - m[7:0]) <= 8'h01);
        rd(tmtc_pkg::mode_ctrl_addr, c);
        chk("level bit", 16'h0089, c);
        wr(tmtc_pkg::mode_ctrl_addr, 8'h01, 8'hff);
        arm_match(m);
        wait_for(1'b0, 1'b1, 400, n);
        chk("no inversion", 16'h0001, timer_out_pin);
        wr(tmtc_pkg::mode_ctrl_addr, 8'h00, 8'hff);
        for (int v = 0; v < 2; v++)
        begin
            @(posedge ref_clk);
            port_latch <= 1'(v);
            @(posedge ref_clk);
            #1;
            chk("port mode pin", 16'(v), timer_out_pin);
        end
        $display("test match done");
    endtask
    task automatic t_capture();
        logic [7:0] r, f, c, e;
        e = 8'h00;
        for (int m = 0; m < 4; m++)
        begin
            wr(tmtc_pkg::mode_ctrl_addr, 8'(m << 4), 8'hff);
            @(posedge ref_clk);
            cap_req <= 1'b1;
            rd(tmtc_pkg::counter_lo_addr, r);
            repeat (20) @(posedge ref_clk);
            cap_req <= 1'b0;
            rd(tmtc_pkg::counter_lo_addr, f);
            rd(tmtc_pkg::capture_lo_addr, c);
            e = (m == 1) ? r : (m >= 2) ? f : e;
            chk("captured count", e, c);
        end
        $display("test capture done");
    endtask
    task automatic t_tone();
        int sh[8] = '{4, 5, 8, 9, 10, 11, 12, 13};
        int n, lim;
        logic [7:0] d;
        logic seen;
        wr(tmtc_pkg::mode_ctrl_addr, 8'h06, 8'hff);
        for (int k = 0; k < 8; k++)
        begin
            lim = 3 * (1 << sh[k]) + 10;
            // upper bits zero, neighbour output off
            wr(tmtc_pkg::tone_ctrl_addr, 8'(k << 1 | 1), 8'hff);
            wait_for(1'b1, 1'b0, lim, n);
            wait_for(1'b1, 1'b1, lim, n);
            wait_for(1'b1, 1'b0, lim, n);
            chk("tone half period", 16'(1 << sh[k]), 16'(n));
        end
        rd(tmtc_pkg::counter_lo_addr, d);
        chk("counter readout blocked", 16'h0000, d);
        wr(tmtc_pkg::tone_ctrl_addr, 8'h00, 8'hff);
        seen = 1'b0;
        repeat (64)
        begin
            @(posedge ref_clk);
            #1;
            seen = seen | tone_out_pin;
        end
        chk("tone pin off", 16'h0000, seen);
        wr(tmtc_pkg::mode_ctrl_addr, 8'h00, 8'hff);
        $display("test tone done");
    endtask
    initial
    begin
        failures = 0;
        check_count = 0;
        srst = 1'b1;
        addr = 16'h0000;
        wr_en = 1'b0;
        rd_en = 1'b0;
        wdata = 8'h00;
        bit_mask = 8'h00;
        port_latch = 1'b0;
        cap_req = 1'b0;
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;
        t_regs();
        t_rates();
        t_match();
        t_capture();
        t_tone();
        final_report();
    end
endmodule
